// File: usmhf_framer.sv
// usmhf_framer.sv: upstream mac-specific header framer, modem transmit side
// assumes command, payload source and byte sink all run on ref_clk
//
// Summary of operation
// R1: request header: type 11, parameter 00010, no ext header, no data after.
// R2: request parameter byte carries total minislots requested.
// R3: request length position carries service identifier, at most 0x1fff.
// R4: request header is exactly six bytes including check sequence.
// R5: service identifier selects one service flow of this modem.
// R6: minislot value is the current total wanted, phy overhead included.
// R7: fragment header: type 11, parameter 00011, ext header flag set.
// R8: fragment parameter byte is 6, six ext header bytes precede check.
// R9: fragment length is payload plus ext header plus fragment crc.
// R10: fragment ends with 4-byte ethernet crc over payload only.
// R11: never put a fragment header on an unsplit frame.
// R12: transmitter implements both fragmentation and concatenation.
// R13: concatenation is upstream only, never downstream.
// R14: concat header: type 11, parameter 11100, no ext header.
// R15: one concat header per burst, no nesting.
// R16: first embedded header follows concat header; lengths locate later frames.
// R17: embedded frames may mix types but share one service flow; raw frames are admitted with any service identifier.
// R18: receiver accepting concatenation handles mixed frame types.
// R19: receiver delivers each embedded frame as if sent alone.
// R20: concat parameter byte is frame count; zero means unspecified.
// R21: concat length is byte total of embedded frames.
// R22: several frames in one burst only inside a concatenation.
// R23: with ext header flag set, parameter byte is ext header length.
// R24: frame control: type bits 7:6, parameter 5:1, ext flag bit 0.
// R25: two-byte header check from a pluggable module.
`timescale 1ns/100ps
`include "usmhf_cfg.svh"
module usmhf_framer import usmhf_pkg::*; (
	input logic ref_clk,
	input logic nrst,
	input logic ce,
	input logic cmd_valid,
	input usmhf_cmd_t cmd,
	output logic cmd_ready,
	input logic pay_valid,
	input logic [7:0] pay_data,
	output logic pay_ready,
	output logic out_valid,
	output usmhf_byte_t out_byte,
	input logic out_ready,
	output logic err,
	output logic in_concat
);
	usmhf_state_t state_r, state_nxt;
	usmhf_kind_t kind_r;
	logic [7:0] hdr_r [0:9];
	logic [3:0] hlen_r, idx_r;
	logic [15:0] rem_r, cat_rem_r, cat_sid_r;
	logic [7:0] cat_cnt_r, cat_frames_r, fbytes_r;
	logic [31:0] crc_r, crc_inv;
	logic [1:0] cidx_r, cnt_r, cnt_nxt;
	logic in_cat_r, first_r, err_r, cmd_ready_r, pay_ready_r, out_valid_r;
	usmhf_byte_t buf_r [0:1];
	usmhf_byte_t pbyte;
	logic take, bad, push, pop, full, pay_xfer, hdr_last, frame_done, wr_idx;
	logic [16:0] crem, flen;
	logic [15:0] hcs;

	function automatic logic [7:0] fc_byte(input logic [4:0] prm, input logic ext);
		return {`USMHF_TYPE_MAC, prm, ext}; // [R24]
	endfunction : fc_byte

	function automatic logic [31:0] crc32_b(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] x;
		x = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ `USMHF_CRC32_POLY) : (x >> 1);
		end
		return x;
	endfunction : crc32_b

	assign cmd_ready = cmd_ready_r;
	assign pay_ready = pay_ready_r;
	assign out_valid = out_valid_r;
	assign out_byte = buf_r[0];
	assign err = err_r;
	assign in_concat = in_cat_r;

	assign take = ce && cmd_valid && cmd_ready_r;
	assign full = cnt_r == 2'h2;
	assign pop = ce && out_valid_r && out_ready;
	assign pay_xfer = ce && pay_valid && pay_ready_r;
	assign hdr_last = idx_r == hlen_r + 4'h1;
	assign crem = {1'b0, cat_rem_r};
	assign flen = {1'b0, cmd.len} + {1'b0, `USMHF_FRAG_OVH};
	assign crc_inv = ~crc_r;

	// refused commands are consumed and flagged, nothing is sent
	always_comb begin
		bad = 1'b0;
		case (cmd.kind)
			USMHF_K_REQ: begin
				bad = cmd.service_ident > `USMHF_SID_MAX; // [R3]
				if (in_cat_r && (cmd.service_ident != cat_sid_r || {1'b0, `USMHF_REQ_BYTES} > crem)) begin
					bad = 1'b1; // [R17]
				end
			end
			USMHF_K_FRAG: begin
				bad = cmd.len >= cmd.pdu_len || cmd.service_ident > `USMHF_SID_MAX; // [R11]
				if (in_cat_r && (cmd.service_ident != cat_sid_r || flen > crem)) begin
					bad = 1'b1; // [R17]
				end
			end
			USMHF_K_CAT: bad = in_cat_r || cmd.len == '0; // [R15]
			default: bad = cmd.len == '0 || (in_cat_r && {1'b0, cmd.len} > crem);
		endcase
	end

	// byte source: header, check sequence, payload or fragment crc
	always_comb begin
		pbyte = '0;
		push = 1'b0;
		frame_done = 1'b0;
		case (state_r)
			ST_HDR: begin
				push = ce && !full;
				if (idx_r < hlen_r) begin
					pbyte.data = hdr_r[idx_r];
				end else if (idx_r == hlen_r) begin
					pbyte.data = hcs[15:8]; // [R25]
				end else begin
					pbyte.data = hcs[7:0];
				end
				frame_done = hdr_last && kind_r == USMHF_K_REQ; // [R4]
			end
			ST_PAY: begin
				push = pay_xfer;
				pbyte.data = pay_data;
				frame_done = rem_r == 16'h0001 && kind_r == USMHF_K_RAW;
			end
			ST_CRC: begin
				push = ce && !full;
				pbyte.data = crc_inv[{cidx_r, 3'b000} +: 8]; // [R10]
				frame_done = cidx_r == `USMHF_CRC_LAST;
			end
			default: push = 1'b0;
		endcase
		pbyte.sop = first_r && !in_cat_r;
		// inside a concatenation the burst closes only when the concatenated total is used up; outside one, at frame end
		pbyte.eop = frame_done && (!in_cat_r || cat_rem_r == 16'h0001); // [R22]
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (take && !bad) begin
					state_nxt = cmd.kind == USMHF_K_RAW ? ST_PAY : ST_HDR;
				end
			end
			ST_HDR: begin
				if (push && hdr_last) begin
					if (kind_r != USMHF_K_FRAG) begin
						state_nxt = ST_IDLE; // [R1]
					end else begin
						state_nxt = rem_r == '0 ? ST_CRC : ST_PAY;
					end
				end
			end
			ST_PAY: begin
				if (pay_xfer && rem_r == 16'h0001) begin
					state_nxt = kind_r == USMHF_K_FRAG ? ST_CRC : ST_IDLE;
				end
			end
			ST_CRC: begin
				if (push && cidx_r == `USMHF_CRC_LAST) begin
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
	assign wr_idx = full || (cnt_r == 2'h1 && !pop);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			cmd_ready_r <= 1'b0;
			pay_ready_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			cmd_ready_r <= state_nxt == ST_IDLE;
			// registered ready: only offered when the buffer has a free slot
			pay_ready_r <= state_nxt == ST_PAY && cnt_nxt != 2'h2;
		end
	end

	// header image built when the command is taken
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			kind_r <= USMHF_K_REQ;
			hlen_r <= `USMHF_HLEN_SHORT;
			for (int i = 0; i < 10; i++) begin
				hdr_r[i] <= '0;
			end
		end else if (take && !bad) begin
			kind_r <= cmd.kind;
			hlen_r <= `USMHF_HLEN_SHORT;
			hdr_r[1] <= cmd.param; // [R2] [R6] [R20]
			{hdr_r[2], hdr_r[3]} <= cmd.len; // [R21]
			case (cmd.kind)
				USMHF_K_REQ: begin
					hdr_r[0] <= fc_byte(`USMHF_PRM_REQ, 1'b0); // [R1]
					{hdr_r[2], hdr_r[3]} <= cmd.service_ident; // [R3] [R5]
				end
				USMHF_K_FRAG: begin
					hdr_r[0] <= fc_byte(`USMHF_PRM_FRAG, 1'b1); // [R7]
					hdr_r[1] <= `USMHF_EHL_FRAG; // [R8] [R23]
					{hdr_r[2], hdr_r[3]} <= cmd.len + `USMHF_FRAG_LENADD; // [R9]
					{hdr_r[4], hdr_r[5], hdr_r[6], hdr_r[7], hdr_r[8], hdr_r[9]} <= cmd.ext_hdr;
					hlen_r <= `USMHF_HLEN_FRAG; // [R8]
				end
				USMHF_K_CAT: hdr_r[0] <= fc_byte(`USMHF_PRM_CAT, 1'b0); // [R14]
				default: hdr_r[0] <= hdr_r[0];
			endcase
		end
	end

	// sequencing counters of the current frame
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			idx_r <= '0;
			cidx_r <= '0;
			rem_r <= '0;
			first_r <= 1'b0;
			fbytes_r <= '0;
		end else if (take && !bad) begin
			idx_r <= '0;
			cidx_r <= '0;
			rem_r <= cmd.len;
			first_r <= 1'b1;
			fbytes_r <= '0;
		end else if (push) begin
			first_r <= 1'b0;
			fbytes_r <= fbytes_r + 8'h01;
			if (state_r == ST_HDR) begin
				idx_r <= idx_r + 4'h1;
			end
			if (state_r == ST_CRC) begin
				cidx_r <= cidx_r + 2'h1;
			end
			if (state_r == ST_PAY) begin
				rem_r <= rem_r - 16'h0001;
			end
		end
	end

	// payload crc; header bytes stay out of it
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			crc_r <= `USMHF_CRC32_INIT;
		end else if (take) begin
			crc_r <= `USMHF_CRC32_INIT;
		end else if (pay_xfer && kind_r == USMHF_K_FRAG) begin
			crc_r <= crc32_b(crc_r, pay_data); // [R10]
		end
	end

	usmhf_hcs u_hcs (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.ce(ce),
		.clr(take),
		.en(push && state_r == ST_HDR && idx_r < hlen_r),
		.din(pbyte.data),
		.crc(hcs)
	); // [R25]

	// concatenation tracking: the body is the following commands' frames
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			in_cat_r <= 1'b0;
			cat_rem_r <= '0;
			cat_sid_r <= '0;
			cat_cnt_r <= '0;
			cat_frames_r <= '0;
		end else if (ce) begin
			if (take && !bad && cmd.kind == USMHF_K_CAT) begin
				cat_rem_r <= cmd.len; // [R21]
				cat_sid_r <= cmd.service_ident; // [R17]
				cat_cnt_r <= cmd.param;
				cat_frames_r <= '0;
			end else if (take && !bad && in_cat_r) begin
				cat_frames_r <= cat_frames_r + 8'h01;
			end
			// upstream-only transmitter, so concatenation never leaves downstream
			if (push && hdr_last && state_r == ST_HDR && kind_r == USMHF_K_CAT) begin
				in_cat_r <= 1'b1; // [R13] [R16]
			end else if (push && in_cat_r) begin
				cat_rem_r <= cat_rem_r - 16'h0001;
				if (cat_rem_r == 16'h0001) begin
					in_cat_r <= 1'b0; // [R12]
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			err_r <= 1'b0;
		end else if (ce) begin
			err_r <= (take && bad) ||
				(push && in_cat_r && cat_rem_r == 16'h0001 && cat_cnt_r != '0 &&
				cat_frames_r != cat_cnt_r); // [R20]
		end
	end

	// two-entry output buffer; a stalled sink loses no byte
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cnt_r <= '0;
			out_valid_r <= 1'b0;
			buf_r[0] <= '0;
			buf_r[1] <= '0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			out_valid_r <= cnt_nxt != '0;
			if (pop) begin
				buf_r[0] <= buf_r[1];
			end
			if (push) begin
				buf_r[wr_idx] <= pbyte;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence s_frag_take;
		take && !bad && cmd.kind == USMHF_K_FRAG;
	endsequence

	sequence s_frag_pay_end;
		state_r == ST_PAY && kind_r == USMHF_K_FRAG && pay_xfer && rem_r == 16'h0001;
	endsequence

	sequence s_cat_close;
		push && in_cat_r && cat_rem_r == 16'h0001;
	endsequence

	AST_REQ_FC: assert property ( // [R1]
		push && state_r == ST_HDR && idx_r == '0 && kind_r == USMHF_K_REQ |-> pbyte.data == 8'hc4)
		else $error("request frame control byte wrong");
	AST_REQ_SIX: assert property ( // [R4]
		push && frame_done && kind_r == USMHF_K_REQ |-> fbytes_r == 8'h05 && pbyte.data == hcs[7:0])
		else $error("request frame not six bytes");
	AST_REQ_SID: assert property ( // [R3]
		take && !bad && cmd.kind == USMHF_K_REQ |=> {hdr_r[2], hdr_r[3]} == $past(cmd.service_ident))
		else $error("service identifier not in length position");
	AST_FRAG_LEN: assert property ( // [R9]
		s_frag_take |=> hdr_r[0] == 8'hc7 && hdr_r[1] == 8'h06 &&
		{hdr_r[2], hdr_r[3]} == $past(cmd.len) + 16'h000a && hlen_r == 4'ha)
		else $error("fragment header fields wrong");
	AST_FRAG_CRC: assert property ( // [R10]
		s_frag_pay_end |=> state_r == ST_CRC && cidx_r == 2'h0)
		else $error("fragment crc not after payload");
	AST_WHOLE: assert property ( // [R11]
		take && cmd.kind == USMHF_K_FRAG && cmd.len >= cmd.pdu_len |=> err_r && state_r == ST_IDLE)
		else $error("unsplit frame got fragment header");
	AST_NEST: assert property ( // [R15]
		take && cmd.kind == USMHF_K_CAT && in_cat_r |=> err_r && in_concat && state_r == ST_IDLE)
		else $error("nested concatenation accepted");
	AST_CAT_END: assert property ( // [R21]
		s_cat_close |-> pbyte.eop ##1 !in_concat)
		else $error("concatenation did not close on length");
	AST_CNT: assert property ( // [R20]
		s_cat_close and (cat_cnt_r != '0 && cat_frames_r != cat_cnt_r) |=> err_r)
		else $error("frame count mismatch not flagged");
	AST_HOLD: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_byte))
		else $error("output byte dropped under stall");
endmodule : usmhf_framer

// File: usmhf_cfg.svh
// usmhf_cfg.svh: constants of the upstream mac-specific header framer
// assumes inclusion by the design files; usmhf_pkg.sv does not include it
`ifndef USMHF_CFG_SVH
`define USMHF_CFG_SVH
// frame control fields
`define USMHF_TYPE_MAC 2'h3
`define USMHF_PRM_REQ 5'h02
`define USMHF_PRM_FRAG 5'h03
`define USMHF_PRM_CAT 5'h1c
// extended header length of a fragment
`define USMHF_EHL_FRAG 8'h06
// header bytes before the check sequence
`define USMHF_HLEN_SHORT 4'h4
`define USMHF_HLEN_FRAG 4'ha
// byte totals of whole frames, fragment length addend, service identifier limit, last crc byte index
`define USMHF_REQ_BYTES 16'h0006
`define USMHF_FRAG_OVH 16'h0010
`define USMHF_FRAG_LENADD 16'h000a
`define USMHF_SID_MAX 16'h1fff
`define USMHF_CRC_LAST 2'h3
// check sequences
`define USMHF_CRC32_POLY 32'hedb88320
`define USMHF_CRC32_INIT 32'hffffffff
`define USMHF_HCS_POLY 16'h1021
`define USMHF_HCS_INIT 16'hffff
`endif

// File: usmhf_pkg.sv
// usmhf_pkg.sv: types of the upstream mac-specific header framer
// assumes nothing; it uses none of the constants header
package usmhf_pkg;
	typedef enum logic [1:0] {
		USMHF_K_REQ = 2'b00,
		USMHF_K_FRAG = 2'b01,
		USMHF_K_CAT = 2'b10,
		USMHF_K_RAW = 2'b11
	} usmhf_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR = 2'b01,
		ST_PAY = 2'b10,
		ST_CRC = 2'b11
	} usmhf_state_t;

	typedef struct packed {
		usmhf_kind_t kind;
		logic [7:0] param;
		logic [15:0] service_ident;
		logic [15:0] len;
		logic [15:0] pdu_len;
		logic [47:0] ext_hdr;
	} usmhf_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic sop;
		logic eop;
	} usmhf_byte_t;
endpackage : usmhf_pkg

// File: usmhf_hcs.sv
// usmhf_hcs.sv: byte-serial header check sequence generator
// assumes bytes arrive msb first, one per enabled cycle
`timescale 1ns/100ps
`include "usmhf_cfg.svh"
module usmhf_hcs import usmhf_pkg::*; #(
	parameter logic [15:0] POLY = `USMHF_HCS_POLY,
	parameter logic [15:0] INIT = `USMHF_HCS_INIT
) (
	input logic ref_clk,
	input logic nrst,
	input logic ce,
	input logic clr,
	input logic en,
	input logic [7:0] din,
	output logic [15:0] crc
);
	logic [15:0] crc_nxt;

	// polynomial is a parameter so another check can be plugged in
	always_comb begin
		crc_nxt = crc ^ {din, 8'h00};
		for (int i = 0; i < 8; i++) begin
			crc_nxt = crc_nxt[15] ? ((crc_nxt << 1) ^ POLY) : (crc_nxt << 1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			crc <= INIT;
		end else if (ce) begin
			if (clr) begin
				crc <= INIT;
			end else if (en) begin
				crc <= crc_nxt;
			end
		end
	end
endmodule : usmhf_hcs

// File: usmhf_sink.sv
// usmhf_sink.sv: byte sink model standing behind the framer's output buffer
// assumes one clock, ref_clk, shared with the framer; stall comes from the bench
`timescale 1ns/100ps
module usmhf_sink import usmhf_pkg::*; (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic stall,
	input wire logic out_valid,
	input wire usmhf_byte_t out_byte,
	output logic out_ready
);
	usmhf_byte_t rx_q[$];
	logic [1:0] ph_r;
	// stall drops ready two cycles in three so the two-entry buffer really fills
	always @(posedge ref_clk) begin
		if (!nrst) begin
			ph_r <= 2'h0;
			out_ready <= 1'b0;
		end else begin
			if (out_valid && out_ready)
				rx_q.push_back(out_byte); // each byte kept as delivered
			ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
			out_ready <= !stall || (ph_r == 2'h2);
		end
	end
endmodule : usmhf_sink

// File: testbench.sv
// testbench.sv: self-checking bench of the upstream header framer
// assumes usmhf_pkg, the framer and the sink model are compiled before it
`timescale 1ns/100ps
module testbench;
	import usmhf_pkg::*;
	logic ref_clk, nrst, ce, cmd_valid, cmd_ready, pay_valid, pay_ready;
	logic out_valid, out_ready, err, in_concat, stall;
	logic [7:0] pay_data;
	usmhf_cmd_t cmd;
	usmhf_byte_t out_byte;
	logic [7:0] pay_q[$];
	logic [7:0] hb[$];
	usmhf_byte_t exp_q[$];
	int err_count, cmp_count, err_hits;

	usmhf_framer dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready),
		.out_valid(out_valid), .out_byte(out_byte), .out_ready(out_ready), .err(err), .in_concat(in_concat));
	usmhf_sink sink (.ref_clk(ref_clk), .nrst(nrst), .stall(stall), .out_valid(out_valid),
		.out_byte(out_byte), .out_ready(out_ready));

	always #50 ref_clk = ~ref_clk;

	// payload source: offers the head of the queue until the framer takes it
	always @(posedge ref_clk) begin
		if (pay_valid && pay_ready)
			void'(pay_q.pop_front());
		pay_valid <= (pay_q.size() != 0);
		pay_data <= (pay_q.size() != 0) ? pay_q[0] : 8'h00;
	end
	// err is a one-cycle pulse, so count it rather than catch the exact edge
	always @(posedge ref_clk) begin
		if (err === 1'b1)
			err_hits++;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic put(input logic [7:0] d);
		exp_q.push_back('{d, 1'b0, 1'b0});
	endtask : put

	// header bytes then crc16 msb first, init all ones, no final xor
	task automatic put_hdr();
		logic [15:0] c;
		c = 16'hffff;
		foreach (hb[i]) begin
			c = c ^ {hb[i], 8'h00};
			repeat (8) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
			put(hb[i]);
		end
		put(c[15:8]);
		put(c[7:0]);
		hb.delete();
	endtask : put_hdr

	// payload bytes, then reflected crc32 inverted, low byte first
	task automatic put_frag(input logic [7:0] p[$]);
		logic [31:0] c;
		c = 32'hffffffff;
		foreach (p[i]) begin
			c = c ^ {24'h0, p[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
			put(p[i]);
			pay_q.push_back(p[i]);
		end
		c = ~c;
		for (int i = 0; i < 4; i++)
			put(c[8*i +: 8]);
	endtask : put_frag

	task automatic send(input usmhf_kind_t k, input logic [7:0] prm, input logic [15:0] service_ident,
		input logic [15:0] len, input logic [15:0] pdu, input int refuse);
		int n, h;
		h = err_hits;
		n = 0;
		cmd <= '{k, prm, service_ident, len, pdu, 48'h0a0b0c0d0e0f};
		cmd_valid <= 1'b1;
		@(posedge ref_clk);
		while (cmd_ready !== 1'b1 && n < 500) begin
			n++;
			@(posedge ref_clk);
		end
		cmd_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check("refusal", err_hits - h, refuse);
	endtask : send

	// one burst: sop on its first byte only, eop on its last byte only
	task automatic expect_rx(input string nm);
		int n;
		n = 0;
		exp_q[0].sop = 1'b1;
		exp_q[exp_q.size() - 1].eop = 1'b1;
		while (sink.rx_q.size() < exp_q.size() && n < 600) begin
			n++;
			@(posedge ref_clk);
		end
		repeat (4) @(posedge ref_clk);
		check({nm, " count"}, sink.rx_q.size(), exp_q.size());
		foreach (exp_q[i])
			if (i < sink.rx_q.size())
				check(nm, sink.rx_q[i], exp_q[i]);
		exp_q.delete();
		sink.rx_q.delete();
	endtask : expect_rx

	task automatic s_request();
		hb = '{8'hc4, 8'h25, 8'h1f, 8'hff};
		put_hdr();
		send(USMHF_K_REQ, 8'h25, 16'h1fff, 16'h0000, 16'h0000, 0);
		expect_rx("request");
	endtask : s_request

	task automatic s_refused();
		send(USMHF_K_REQ, 8'h01, 16'h2000, 16'h0000, 16'h0000, 1);
		send(USMHF_K_FRAG, 8'h06, 16'h0005, 16'h0004, 16'h0004, 1); // whole frame
		send(USMHF_K_RAW, 8'h00, 16'h0000, 16'h0000, 16'h0000, 1);
		send(USMHF_K_CAT, 8'h00, 16'h0005, 16'h0000, 16'h0000, 1);
		repeat (8) @(posedge ref_clk);
		check("refused output", sink.rx_q.size(), 0);
	endtask : s_refused

	// stall held throughout, sink ready one cycle in three, so the buffer fills and refuses
	task automatic s_fragment();
		stall <= 1'b1;
		hb = '{8'hc7, 8'h06, 8'h00, 8'h0d, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
		put_hdr();
		put_frag('{8'h11, 8'h22, 8'h33});
		send(USMHF_K_FRAG, 8'h06, 16'h0007, 16'h0003, 16'h0028, 0);
		expect_rx("fragment");
		stall <= 1'b0;
	endtask : s_fragment

	// concat of a request and a three-byte raw frame; count mismatch flagged
	task automatic s_concat(input logic [7:0] cnt, input int bad);
		int h;
		hb = '{8'hf8, cnt, 8'h00, 8'h09};
		put_hdr();
		hb = '{8'hc4, 8'h10, 8'h00, 8'h42};
		put_hdr();
		put(8'haa);
		put(8'hbb);
		put(8'hcc);
		pay_q = '{8'haa, 8'hbb, 8'hcc};
		send(USMHF_K_CAT, cnt, 16'h0042, 16'h0009, 16'h0000, 0);
		// concat flag rises only after the header's last byte, so look once it is back idle
		send(USMHF_K_CAT, 8'h01, 16'h0042, 16'h0006, 16'h0000, 1); // nested
		check("in concat", in_concat, 1'b1);
		send(USMHF_K_REQ, 8'h10, 16'h0043, 16'h0000, 16'h0000, 1); // other flow
		h = err_hits;
		send(USMHF_K_REQ, 8'h10, 16'h0042, 16'h0000, 16'h0000, 0);
		send(USMHF_K_RAW, 8'h00, 16'h0000, 16'h0003, 16'h0000, 0);
		expect_rx("concat");
		check("count flag", err_hits - h, bad);
		check("concat done", in_concat, 1'b0);
	endtask : s_concat

	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		ce = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		pay_valid = 1'b0;
		pay_data = 8'h00;
		stall = 1'b0;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		s_request();
		s_refused();
		s_fragment();
		s_concat(8'h02, 0);
		s_concat(8'h00, 0); // unspecified count
		s_concat(8'h03, 1);
		end_of_test();
	end

	// whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		end_of_test();
	end
endmodule : testbench
